// ===== design/ttm_pkg.sv
// constants, types and helpers for the telegram timeout monitor
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register port
package ttm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_P1_SEL = 8'h00;
    localparam logic [7:0] OFS_P1_TMO = 8'h04;
    localparam logic [7:0] OFS_P2_SEL = 8'h08;
    localparam logic [7:0] OFS_P2_TMO = 8'h0c;
    localparam logic [7:0] OFS_P2_LINE = 8'h10;
    localparam logic [7:0] OFS_P3_SEL = 8'h14;
    localparam logic [7:0] OFS_P3_TMO = 8'h18;
    localparam logic [7:0] OFS_P3_LINE = 8'h1c;
    localparam logic [7:0] OFS_PL_MODE = 8'h20;
    localparam logic [7:0] OFS_PL_TMO = 8'h24;
    localparam logic [7:0] OFS_OP_STATE = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2c;
    localparam logic [7:0] OFS_MASK = 8'h30;
    localparam logic [7:0] OFS_RECORD = 8'h34;
    localparam logic [7:0] OFS_ARMED = 8'h38;

    ////////////////////////////////////////////////////////////////////////
    // setting codes and fault numbers
    localparam logic [7:0] PROTO_MS = 8'h02;
    localparam logic [7:0] PROTO_PEER_A = 8'h04;
    localparam logic [7:0] PROTO_PEER_B = 8'h05;
    localparam logic [7:0] LINE_A = 8'h20;
    localparam logic [7:0] LINE_B = 8'h21;
    localparam logic [7:0] PLMODE_A = 8'h01;
    localparam logic [7:0] PLMODE_B = 8'h02;
    localparam logic [3:0] OPSTATE_PEER_MAX = 4'h6;
    localparam logic [7:0] FAULT_P1 = 8'h0b;
    localparam logic [7:0] FAULT_P2 = 8'h0c;
    localparam logic [7:0] FAULT_P3 = 8'h0d;
    localparam logic [7:0] FAULT_PL = 8'h0e;

    // channel indices, also the status/mask/armed bit positions
    localparam int NCH = 4;
    localparam int CH_P1 = 0;
    localparam int CH_P2 = 1;
    localparam int CH_P3 = 2;
    localparam int CH_PL = 3;

    ////////////////////////////////////////////////////////////////////////
    // reset values and timing
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [15:0] TMO_RESET = 16'h0064;
    localparam logic [3:0] OPSTATE_RESET = 4'h0;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_DEFAULT_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic {CH_WAIT_FIRST, CH_WATCHING} ttm_chan_state_t;

    // all software settings travel together
    typedef struct packed {
        logic [7:0] port1ProtocolSelect;
        logic [15:0] port1TelegramTimeout;
        logic [7:0] port2ProtocolSelect;
        logic [15:0] port2TelegramTimeout;
        logic [7:0] port2LineSetting;
        logic [7:0] port3ProtocolSelect;
        logic [15:0] port3TelegramTimeout;
        logic [7:0] port3LineSetting;
        logic [7:0] parallelLinkMode;
        logic [15:0] parallelLinkTimeout;
        logic [3:0] opState;
    } ttm_cfg_t;

    function automatic logic isPeer(input logic [7:0] sel);
        return (sel == PROTO_PEER_A) || (sel == PROTO_PEER_B);
    endfunction

    function automatic logic isLine(input logic [7:0] line);
        return (line == LINE_A) || (line == LINE_B);
    endfunction

endpackage

// ===== design/ttm_channel.sv
// one telegram-loss watchdog for a single interface
// assumes a one-cycle telegram pulse and a one-cycle millisecond tick
`timescale 1ns/1ns
`default_nettype none
module ttm_channel
    import ttm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic monitorOn,
    input wire logic telegram,
    input wire logic tick,
    input wire logic [15:0] timeout,
    output logic armed,
    output logic lossPulse
);

    ttm_chan_state_t state, next_state;
    logic [15:0] elapsed, next_elapsed;
    logic next_loss;
    logic [16:0] elapsedPlus;

    ////////////////////////////////////////////////////////////////////////
    // next values; a disabled monitor holds state and elapsed still and raises no loss pulse
    always_comb begin
        elapsedPlus = {1'b0, elapsed} + 17'h00001;
        next_state = state;
        next_elapsed = elapsed;
        next_loss = 1'b0;
        if (monitorOn) begin
            if (telegram) begin
                next_state = CH_WATCHING;
                next_elapsed = 16'h0000;
            end else if (state == CH_WATCHING && tick) begin
                if (elapsedPlus >= {1'b0, timeout}) begin
                    // report once, then wait for traffic to re-arm
                    next_loss = 1'b1;
                    next_state = CH_WAIT_FIRST;
                    next_elapsed = 16'h0000;
                end else begin
                    next_elapsed = elapsedPlus[15:0];
                end
            end
        end
    end

    // registers only; a pending loss pulse is held while ce is low,
    // otherwise the top would miss it when ce drops right after it
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= CH_WAIT_FIRST;
            elapsed <= 16'h0000;
            lossPulse <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            elapsed <= next_elapsed;
            lossPulse <= next_loss;
        end
    end

    assign armed = (state == CH_WATCHING);

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_loss_armed: assert property (
        @(posedge clk) disable iff (reset)
        $rose(lossPulse) |-> $past(state) == CH_WATCHING)
        else $error("loss reported before first telegram");

    chk_loss_time: assert property (
        @(posedge clk) disable iff (reset)
        $rose(lossPulse) |-> ({1'b0, $past(elapsed)} + 17'h00001)
            >= {1'b0, $past(timeout)})
        else $error("loss reported before timeout elapsed");

    chk_telegram_restart: assert property (
        @(posedge clk) disable iff (reset)
        (ce && monitorOn && telegram) |=>
            (elapsed == 16'h0000 && state == CH_WATCHING && !lossPulse))
        else $error("telegram did not restart the timeout");

    chk_frozen_off: assert property (
        @(posedge clk) disable iff (reset)
        (ce && !monitorOn) |=>
            ($stable(elapsed) && $stable(state) && !lossPulse))
        else $error("disabled monitor kept counting");

endmodule
`default_nettype wire

// ===== design/ttm_top.sv
// telegram timeout monitor: four interface watchdogs behind AXI4-Lite
// assumes telegram pulses are synchronous one-cycle strobes on clk
//
// Summary of operation
// - port 1 watched only when protocol select is 2; loss is fault 11
// - port 1 armed: no telegram within its timeout raises fault 11
// - port 2 master-slave mode (select 2) watched always; fault 12
// - port 2 armed: no telegram within its timeout raises fault 12
// - port 2 peer mode: select 4/5, line 32/33, states o6 or lower
// - port 3 master-slave: select 2 and line 32/33; fault 13
// - port 3 peer mode: select 4 or 5, states o6 or lower only
// - port 3 armed: no telegram within its timeout raises fault 13
// - paralleling link watched for mode 1 or 2; loss is fault 14
// - no loss fault before the first telegram; partner keeps sending
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module ttm_top
    import ttm_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_DEFAULT_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [NCH-1:0] telegramValid,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    // byte-lane merge used for every writable register
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // millisecond tick prescaler
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    logic [15:0] tickCount, next_tickCount;
    logic tick, next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_tickCount = tickCount + 16'h0001;
        if (tickCount >= TICK_LAST) begin
            next_tickCount = 16'h0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tickCount <= 16'h0000;
            tick <= 1'b0;
        end else if (ce) begin
            tickCount <= next_tickCount;
            tick <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order
    logic awTaken, next_awTaken, wTaken, next_wTaken;
    logic [ADDR_W-1:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic next_awready, next_wready, next_bvalid;
    logic [1:0] next_bresp;
    logic wrFire;
    logic wrMapped;

    // a write lands one edge after both halves are held
    assign wrFire = awTaken && wTaken && !s_axi_bvalid;

    always_comb begin
        unique case (awAddr)
            OFS_P1_SEL, OFS_P1_TMO, OFS_P2_SEL, OFS_P2_TMO, OFS_P2_LINE,
            OFS_P3_SEL, OFS_P3_TMO, OFS_P3_LINE, OFS_PL_MODE, OFS_PL_TMO,
            OFS_OP_STATE, OFS_STATUS, OFS_MASK, OFS_RECORD,
            OFS_ARMED: wrMapped = 1'b1;
            default: wrMapped = 1'b0;
        endcase
    end

    always_comb begin
        next_awTaken = awTaken;
        next_awAddr = awAddr;
        next_wTaken = wTaken;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awready && s_axi_awvalid) begin
            next_awTaken = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wready && s_axi_wvalid) begin
            next_wTaken = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (wrFire) begin
            next_awTaken = 1'b0;
            next_wTaken = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wrMapped ? RESP_OKAY : RESP_SLVERR;
        end
        // one write at a time: stay closed until the response is taken
        next_awready = !next_awTaken && !next_bvalid;
        next_wready = !next_wTaken && !next_bvalid;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            awTaken <= 1'b0;
            awAddr <= '0;
            wTaken <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (ce) begin
            awTaken <= next_awTaken;
            awAddr <= next_awAddr;
            wTaken <= next_wTaken;
            wData <= next_wData;
            wStrb <= next_wStrb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settings, fault status, mask and fault record
    ttm_cfg_t cfg, next_cfg;
    logic [NCH-1:0] faultStatus, next_faultStatus;
    logic [NCH-1:0] faultMask, next_faultMask;
    logic [7:0] faultValueRecord, next_faultValueRecord;
    logic [NCH-1:0] chLoss, chArmed, monEn;
    logic [31:0] mergedWord;
    logic [NCH-1:0] clearBits;
    logic next_irq;

    assign mergedWord = merge(32'h00000000, wData, wStrb);

    always_comb begin
        next_cfg = cfg;
        next_faultMask = faultMask;
        clearBits = '0;
        if (wrFire) begin
            unique case (awAddr)
                OFS_P1_SEL: next_cfg.port1ProtocolSelect =
                    8'(merge({24'h0, cfg.port1ProtocolSelect}, wData, wStrb));
                OFS_P1_TMO: next_cfg.port1TelegramTimeout =
                    16'(merge({16'h0, cfg.port1TelegramTimeout}, wData, wStrb));
                OFS_P2_SEL: next_cfg.port2ProtocolSelect =
                    8'(merge({24'h0, cfg.port2ProtocolSelect}, wData, wStrb));
                OFS_P2_TMO: next_cfg.port2TelegramTimeout =
                    16'(merge({16'h0, cfg.port2TelegramTimeout}, wData, wStrb));
                OFS_P2_LINE: next_cfg.port2LineSetting =
                    8'(merge({24'h0, cfg.port2LineSetting}, wData, wStrb));
                OFS_P3_SEL: next_cfg.port3ProtocolSelect =
                    8'(merge({24'h0, cfg.port3ProtocolSelect}, wData, wStrb));
                OFS_P3_TMO: next_cfg.port3TelegramTimeout =
                    16'(merge({16'h0, cfg.port3TelegramTimeout}, wData, wStrb));
                OFS_P3_LINE: next_cfg.port3LineSetting =
                    8'(merge({24'h0, cfg.port3LineSetting}, wData, wStrb));
                OFS_PL_MODE: next_cfg.parallelLinkMode =
                    8'(merge({24'h0, cfg.parallelLinkMode}, wData, wStrb));
                OFS_PL_TMO: next_cfg.parallelLinkTimeout =
                    16'(merge({16'h0, cfg.parallelLinkTimeout}, wData, wStrb));
                OFS_OP_STATE: next_cfg.opState =
                    4'(merge({28'h0, cfg.opState}, wData, wStrb));
                OFS_MASK: next_faultMask =
                    NCH'(merge({28'h0, faultMask}, wData, wStrb));
                OFS_STATUS: clearBits = mergedWord[NCH-1:0];
                default: ;
            endcase
        end
        // a loss in the clearing cycle survives the clear
        next_faultStatus = (faultStatus & ~clearBits) | chLoss;
        // lowest fault number wins when two land together
        next_faultValueRecord = faultValueRecord;
        if (chLoss[CH_PL]) next_faultValueRecord = FAULT_PL;
        if (chLoss[CH_P3]) next_faultValueRecord = FAULT_P3;
        if (chLoss[CH_P2]) next_faultValueRecord = FAULT_P2;
        if (chLoss[CH_P1]) next_faultValueRecord = FAULT_P1;
        next_irq = |(next_faultStatus & next_faultMask);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg <= '{SEL_RESET, TMO_RESET, SEL_RESET, TMO_RESET, SEL_RESET,
                     SEL_RESET, TMO_RESET, SEL_RESET, SEL_RESET, TMO_RESET,
                     OPSTATE_RESET};
            faultStatus <= '0;
            faultMask <= '0;
            faultValueRecord <= 8'h00;
            irq <= 1'b0;
        end else if (ce) begin
            cfg <= next_cfg;
            faultStatus <= next_faultStatus;
            faultMask <= next_faultMask;
            faultValueRecord <= next_faultValueRecord;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // monitor enables from protocol, line, mode and state settings
    logic stateLowEnough;
    assign stateLowEnough = (cfg.opState <= OPSTATE_PEER_MAX);

    always_comb begin
        monEn[CH_P1] = (cfg.port1ProtocolSelect == PROTO_MS);
        monEn[CH_P2] = (cfg.port2ProtocolSelect == PROTO_MS)
            || (isPeer(cfg.port2ProtocolSelect)
                && isLine(cfg.port2LineSetting) && stateLowEnough);
        monEn[CH_P3] = ((cfg.port3ProtocolSelect == PROTO_MS)
                && isLine(cfg.port3LineSetting))
            || (isPeer(cfg.port3ProtocolSelect)
                && stateLowEnough);
        monEn[CH_PL] = (cfg.parallelLinkMode == PLMODE_A)
            || (cfg.parallelLinkMode == PLMODE_B);
    end

    // one watchdog per interface, each with its own timeout
    logic [15:0] chTimeout [NCH];
    assign chTimeout[CH_P1] = cfg.port1TelegramTimeout;
    assign chTimeout[CH_P2] = cfg.port2TelegramTimeout;
    assign chTimeout[CH_P3] = cfg.port3TelegramTimeout;
    assign chTimeout[CH_PL] = cfg.parallelLinkTimeout;

    for (genvar g = 0; g < NCH; g++) begin : gen_ch
        ttm_channel u_ch (
            .clk(clk),
            .reset(reset),
            .ce(ce),
            .monitorOn(monEn[g]),
            .telegram(telegramValid[g]),
            .tick(tick),
            .timeout(chTimeout[g]),
            .armed(chArmed[g]),
            .lossPulse(chLoss[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel: data one edge after the address is taken
    logic next_arready, next_rvalid;
    logic [31:0] next_rdata, rdMux;
    logic [1:0] next_rresp, rdResp;

    always_comb begin
        rdResp = RESP_OKAY;
        unique case (s_axi_araddr)
            OFS_P1_SEL: rdMux = {24'h0, cfg.port1ProtocolSelect};
            OFS_P1_TMO: rdMux = {16'h0, cfg.port1TelegramTimeout};
            OFS_P2_SEL: rdMux = {24'h0, cfg.port2ProtocolSelect};
            OFS_P2_TMO: rdMux = {16'h0, cfg.port2TelegramTimeout};
            OFS_P2_LINE: rdMux = {24'h0, cfg.port2LineSetting};
            OFS_P3_SEL: rdMux = {24'h0, cfg.port3ProtocolSelect};
            OFS_P3_TMO: rdMux = {16'h0, cfg.port3TelegramTimeout};
            OFS_P3_LINE: rdMux = {24'h0, cfg.port3LineSetting};
            OFS_PL_MODE: rdMux = {24'h0, cfg.parallelLinkMode};
            OFS_PL_TMO: rdMux = {16'h0, cfg.parallelLinkTimeout};
            OFS_OP_STATE: rdMux = {28'h0, cfg.opState};
            OFS_STATUS: rdMux = {28'h0, faultStatus};
            OFS_MASK: rdMux = {28'h0, faultMask};
            OFS_RECORD: rdMux = {24'h0, faultValueRecord};
            OFS_ARMED: rdMux = {28'h0, chArmed};
            default: begin
                rdMux = 32'h00000000;
                rdResp = RESP_SLVERR;
            end
        endcase
    end

    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arready && s_axi_arvalid) begin
            next_rvalid = 1'b1;
            next_rdata = rdMux;
            next_rresp = rdResp;
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_p1_fault_cause: assert property (
        @(posedge clk) disable iff (reset)
        (ce && chLoss[CH_P1]) |-> $past(monEn[CH_P1])
            ##1 (faultStatus[CH_P1] && faultValueRecord == FAULT_P1))
        else $error("port 1 fault without master-slave setting");

    chk_p2_peer_state: assert property (
        @(posedge clk) disable iff (reset)
        (cfg.port2ProtocolSelect != PROTO_MS
            && cfg.opState > OPSTATE_PEER_MAX) |-> !monEn[CH_P2])
        else $error("port 2 watched above state o6");

    chk_p3_ms_line: assert property (
        @(posedge clk) disable iff (reset)
        (cfg.port3ProtocolSelect == PROTO_MS
            && !isLine(cfg.port3LineSetting)) |-> !monEn[CH_P3])
        else $error("port 3 watched with wrong line setting");

    chk_p3_peer_on: assert property (
        @(posedge clk) disable iff (reset)
        (isPeer(cfg.port3ProtocolSelect) && cfg.opState <= 4'h6)
            |-> monEn[CH_P3])
        else $error("port 3 peer monitor not enabled");

    chk_pl_fault_set: assert property (
        @(posedge clk) disable iff (reset)
        (ce && chLoss[CH_PL]) |=> faultStatus[CH_PL])
        else $error("paralleling loss not latched");

    chk_set_beats_clear: assert property (
        @(posedge clk) disable iff (reset)
        (ce && chLoss[CH_P2] && wrFire && awAddr == OFS_STATUS)
            |=> faultStatus[CH_P2])
        else $error("clear swallowed a simultaneous loss");

    chk_irq_level: assert property (
        @(posedge clk) disable iff (reset)
        irq == |(faultStatus & faultMask))
        else $error("interrupt does not follow status and mask");

    chk_read_answer: assert property (
        @(posedge clk) disable iff (reset)
        (ce && s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read not answered on next edge");

endmodule
`default_nettype wire

// ===== bench/ttm_far_party.sv
// far-side sender of telegram strobes for the monitor bench
// assumes one clock shared with the monitor
`timescale 1ns/1ns
`default_nettype none
module ttm_far_party (
    input wire logic clk,
    input wire logic [3:0] run,
    output logic [3:0] telegram
);
    int n = 0;
    // one strobe every third cycle, well inside the shortest timeout
    always @(posedge clk) begin
        n <= (n == 2) ? 0 : n + 1;
        telegram <= (n == 2) ? run : 4'h0;
    end
endmodule
`default_nettype wire

// ===== bench/telegram_timeout_monitor_tb.sv
// self-checking bench for the telegram timeout monitor
// assumes a four-cycle tick so that timeouts stay short
`timescale 1ns/1ns
`default_nettype none
module telegram_timeout_monitor_tb;
    import ttm_pkg::*;
    logic clk = 0, reset = 1, awv = 0, wv = 0, bra = 0, arv = 0, rra = 0;
    logic awRdy, wRdy, bVal, arRdy, rVal, irq;
    logic [7:0] aa = 8'h00, ra = 8'h00;
    logic [31:0] wd = 32'h0, rData, v;
    logic [1:0] bResp, rResp, r;
    logic [3:0] run = 4'h0, tel;
    int err_total = 0, tests_run = 0, es, rb;
    int tm[4];
    logic [1:0] wb;
    int c[4][7] = '{'{2, 2, 0, 2, 32, 1, 0}, '{4, 4, 33, 2, 0, 2, 7},
        '{0, 5, 32, 4, 0, 0, 6}, '{2, 4, 33, 5, 33, 0, 3}};
    logic [7:0] oa[7] = '{OFS_P1_SEL, OFS_P2_SEL, OFS_P2_LINE,
        OFS_P3_SEL, OFS_P3_LINE, OFS_PL_MODE, OFS_OP_STATE};
    logic [7:0] ta[4] = '{OFS_P1_TMO, OFS_P2_TMO, OFS_P3_TMO, OFS_PL_TMO};
    always #50 clk = ~clk;
    ttm_top #(.TICK_CYCLES(4)) i_dut (.clk(clk), .reset(reset),
        .ce(1'b1), .telegramValid(tel), .s_axi_awaddr(aa),
        .s_axi_awvalid(awv), .s_axi_awready(awRdy), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wRdy),
        .s_axi_bresp(bResp), .s_axi_bvalid(bVal), .s_axi_bready(bra),
        .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arRdy),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rVal),
        .s_axi_rready(rra), .irq(irq));
    ttm_far_party i_far (.clk(clk), .run(run), .telegram(tel));
    ////////////////////////////////////////////////////////////////////
    // reference: which watchdogs a setting enables
    function automatic int en(int ch, int s[7]);
        bit pe2 = s[1] inside {4, 5} && s[2] inside {32, 33} && s[6] <= 6;
        bit ms3 = s[3] == 2 && s[4] inside {32, 33};
        bit pe3 = s[3] inside {4, 5} && s[6] <= 6;
        case (ch)
            0: return int'(s[0] == 2);
            1: return int'(s[1] == 2 || pe2);
            2: return int'(ms3 || pe3);
            default: return int'(s[5] inside {1, 2});
        endcase
    endfunction
    // address and data together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        aa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        do begin
            @(posedge clk);
            if (awRdy) awv <= 0;
            if (wRdy) wv <= 0;
        end while (awv || wv);
        bra <= 1;
        do @(posedge clk); while (!bVal);
        wb = bResp;
        bra <= 0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] q);
        ra <= a;
        arv <= 1;
        do @(posedge clk); while (!arRdy);
        arv <= 0;
        rra <= 1;
        do @(posedge clk); while (!rVal);
        d = rData;
        q = rResp;
        rra <= 0;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            err_total++;
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // per setting: silent, then fed, then starved
    initial begin
        void'($urandom(73));
        repeat (8) @(posedge clk);
        reset <= 0;
        repeat (2) @(posedge clk);
        rd(OFS_P1_TMO, v, r);
        chk(v, {16'h0, TMO_RESET});
        rd(8'h3c, v, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h3c, 32'h0);
        chk({30'h0, wb}, {30'h0, RESP_SLVERR});
        wr(OFS_MASK, 32'hf);
        chk({30'h0, wb}, {30'h0, RESP_OKAY});
        for (int k = 0; k < 4; k++) begin
            es = 0;
            for (int i = 0; i < 7; i++) wr(oa[i], 32'(c[k][i]));
            for (int i = 0; i < 4; i++) begin
                tm[i] = 2 + $urandom % 3;
                wr(ta[i], 32'(tm[i]));
                es |= en(i, c[k]) << i;
            end
            wr(OFS_STATUS, 32'hf);
            repeat (40) @(posedge clk);
            rd(OFS_STATUS, v, r);
            chk(v, 32'h0);
            run <= 4'hf;
            repeat (60) @(posedge clk);
            rd(OFS_ARMED, v, r);
            chk(v, 32'(es));
            rd(OFS_STATUS, v, r);
            chk(v, 32'h0);
            run <= 4'h0;
            repeat (60) @(posedge clk);
            rd(OFS_STATUS, v, r);
            chk(v, 32'(es));
            chk({31'h0, irq}, 32'(es != 0));
            // all channels starve together: longest timeout reports last,
            // lowest fault number on a tie
            rb = -1;
            for (int i = 0; i < 4; i++)
                if (es[i] && (rb < 0 || tm[i] > tm[rb])) rb = i;
            rd(OFS_RECORD, v, r);
            chk(v, 32'(11 + rb));
            $display("test %0d done", k);
        end
        end_sim;
    end
    // hang guard, far beyond the fewer than a thousand cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim;
    end
endmodule
`default_nettype wire
